// ### verilog/sfe_exception_unit.sv
// Packed floating-point exception detection and reporting unit.
// Assumes the pipeline offers operand classes, then result status,
// one operation at a time, and a classic Wishbone register master.
//
// Behaviour
// - Six conditions each own a sticky flag and a mask bit in the control/status word.
// - Invalid, divide-by-zero and denormal are judged from operands before arithmetic.
// - Overflow, underflow and inexact are judged only from the computed result.
// - A masked condition sets its flag, takes the default result and lets execution go on.
// - An unmasked condition with OS support set raises the SIMD fault on vector 19.
// - An unmasked condition with OS support clear raises the invalid-opcode fault.
// - The SIMD fault is raised only for a condition whose flag is set and mask clear.
// - Unmasked conditions fault on the instruction itself and are never held pending.
// - Clearing a mask over an already set flag raises nothing.
// - Every condition found in any of two or four sub-operands sets its flag.
// - Within one sub-operand a NaN or an unmasked level three or four condition hides all lower ones.
// - Priority runs NaN invalid, quiet NaN, other invalid or divide, denormal, range, inexact.
// - A quiet NaN operand suppresses all lower conditions in its sub-operand.
// - A masked level three or four condition, or any level five one, lets lower ones in that sub-operand be seen.
// - A fault saves the pointer of the instruction that caused it.
module sfe_exception_unit
	import sfe_pkg::*;
#(
	parameter int LANES = 4,
	parameter int IP_W  = 32
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [DATA_W-1:0] dat_i,
	output logic      [DATA_W-1:0] dat_o,
	output logic                   ack_o,
	// Operand classes
	input  wire logic              pre_valid_i,
	input  wire logic [LANES-1:0]  lane_en_i,
	input  wire logic              nan_strict_i,
	input  wire logic [LANES-1:0]  snan_i,
	input  wire logic [LANES-1:0]  qnan_i,
	input  wire logic [LANES-1:0]  inv_other_i,
	input  wire logic [LANES-1:0]  div_zero_i,
	input  wire logic [LANES-1:0]  denorm_i,
	input  wire logic [IP_W-1:0]   instr_ptr_i,
	// Result status
	input  wire logic              post_valid_i,
	input  wire logic [LANES-1:0]  overflow_i,
	input  wire logic [LANES-1:0]  underflow_i,
	input  wire logic [LANES-1:0]  inexact_i,
	// Verdicts
	output logic                   pre_done_o,
	output logic                   proceed_o,
	output logic                   post_done_o,
	output logic [LANES-1:0]       default_lanes_o,
	// Fault dispatch
	output logic                   simd_fp_fault_o,
	output logic                   invalid_opcode_fault_o,
	output logic [7:0]             fault_vector_o,
	output logic [IP_W-1:0]        fault_ip_o,
	output logic                   error_code_push_o,
	// Interrupt
	output logic                   irq_o
);

	// ==========================================================
	// Byte lane merge
	function automatic logic [31:0] wb_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// State
	sfe_state_t             state;
	logic [NCOND-1:0]       flags;
	logic [NCOND-1:0]       masks;
	logic                   os_unmasked_simd_support;
	logic [LANES-1:0]       blocked;
	logic [IP_W-1:0]        op_ip;
	logic [IP_W-1:0]        fault_ip;
	logic [7:0]             info_vec;
	logic [LANES-1:0]       info_lanes;
	logic [IRQ_W-1:0]       irq_stat;
	logic [IRQ_W-1:0]       irq_en;

	// ==========================================================
	// Lane results
	logic [NCOND-1:0]       pre_flag  [LANES];
	logic [NCOND-1:0]       post_flag [LANES];
	logic [LANES-1:0]       pre_unm;
	logic [LANES-1:0]       post_unm;
	logic [LANES-1:0]       pre_blk;
	logic [NCOND-1:0]       pre_any;
	logic [NCOND-1:0]       post_any;
	logic [LANES-1:0]       pre_dflt;
	logic [LANES-1:0]       post_dflt;

	// ==========================================================
	// Decode and events
	logic                   take_pre;
	logic                   take_post;
	logic                   wr_take;
	logic [31:0]            csr_word;
	logic [31:0]            ctrl_word;
	logic [31:0]            rd_word;
	logic [NCOND-1:0]       cond_set;
	logic                   hit;
	logic [LANES-1:0]       hit_lanes;
	logic                   raise;
	logic [IRQ_W-1:0]       ev;
	logic [IRQ_W-1:0]       irq_clr;
	logic [IRQ_W-1:0]       next_irq_stat;

	assign take_pre  = (state == ST_IDLE) & pre_valid_i;
	assign take_post = (state == ST_ARITH) & post_valid_i;
	assign wr_take   = cyc_i & stb_i & we_i & ack_o;

	// ==========================================================
	// Per sub-operand classifiers
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		sfe_pre_lane u_pre (
			.en_i         (lane_en_i[l]),
			.nan_strict_i (nan_strict_i),
			.snan_i       (snan_i[l]),
			.qnan_i       (qnan_i[l]),
			.inv_other_i  (inv_other_i[l]),
			.div_zero_i   (div_zero_i[l]),
			.denorm_i     (denorm_i[l]),
			.mask_i       (masks),
			.flag_o       (pre_flag[l]),
			.unmasked_o   (pre_unm[l]),
			.block_o      (pre_blk[l])
		);
		sfe_post_lane u_post (
			.en_i        (lane_en_i[l] & ~blocked[l]),
			.overflow_i  (overflow_i[l]),
			.underflow_i (underflow_i[l]),
			.inexact_i   (inexact_i[l]),
			.mask_i      (masks),
			.flag_o      (post_flag[l]),
			.unmasked_o  (post_unm[l])
		);
	end

	// ==========================================================
	// Gather sub-operand conditions
	always_comb begin
		pre_any = '0;
		post_any = '0;
		for (int l = 0; l < LANES; l++) begin
			pre_any = pre_any | pre_flag[l];
			post_any = post_any | post_flag[l];
			pre_dflt[l] = pre_blk[l] | (|pre_flag[l]);
			post_dflt[l] = |post_flag[l];
		end
	end

	// ==========================================================
	// Stage verdict
	always_comb begin
		cond_set = '0;
		hit = 1'b0;
		hit_lanes = '0;
		if (take_pre) begin
			cond_set = pre_any;
			hit = |pre_unm;
			hit_lanes = pre_unm;
		end else if (take_post) begin
			cond_set = post_any;
			hit = |post_unm;
			hit_lanes = post_unm;
		end
		raise = hit & os_unmasked_simd_support;
	end

	// ==========================================================
	// Operation sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			blocked <= '0;
			op_ip <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take_pre) begin
						blocked <= pre_blk;
						op_ip <= instr_ptr_i;
						if (!hit) begin
							state <= ST_ARITH;
						end
					end
				end
				ST_ARITH: begin
					if (take_post) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Verdict outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_done_o <= 1'b0;
			proceed_o <= 1'b0;
			post_done_o <= 1'b0;
			default_lanes_o <= '0;
		end else begin
			pre_done_o <= take_pre;
			proceed_o <= take_pre & ~hit;
			post_done_o <= take_post;
			if (take_pre) begin
				default_lanes_o <= pre_dflt;
			end else if (take_post) begin
				default_lanes_o <= post_dflt;
			end
		end
	end

	// ==========================================================
	// Fault dispatch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			simd_fp_fault_o <= 1'b0;
			invalid_opcode_fault_o <= 1'b0;
			fault_vector_o <= 8'h00;
			fault_ip_o <= '0;
			error_code_push_o <= 1'b0;
		end else begin
			simd_fp_fault_o <= raise;
			invalid_opcode_fault_o <= hit & ~os_unmasked_simd_support;
			error_code_push_o <= 1'b0;
			if (hit) begin
				fault_vector_o <= raise ? VEC_SIMD_FP : VEC_INV_OP;
				fault_ip_o <= take_pre ? instr_ptr_i : op_ip;
			end
		end
	end

	// ==========================================================
	// Last fault record
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_ip <= '0;
			info_vec <= 8'h00;
			info_lanes <= '0;
		end else if (hit) begin
			fault_ip <= take_pre ? instr_ptr_i : op_ip;
			info_vec <= raise ? VEC_SIMD_FP : VEC_INV_OP;
			info_lanes <= hit_lanes;
		end
	end

	// ==========================================================
	// Control and status word
	always_comb begin
		csr_word = '0;
		csr_word[CSR_FLAG_LSB +: NCOND] = flags;
		csr_word[CSR_MASK_LSB +: NCOND] = masks;
		ctrl_word = '0;
		ctrl_word[CTRL_OSX_BIT] = os_unmasked_simd_support;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= FLAG_RESET;
			masks <= MASK_RESET;
		end else if (wr_take && adr_i == OFF_CSR) begin
			flags <= NCOND'(wb_merge(csr_word, dat_i, sel_i) >> CSR_FLAG_LSB)
				| cond_set;
			masks <= NCOND'(wb_merge(csr_word, dat_i, sel_i) >> CSR_MASK_LSB);
		end else begin
			flags <= flags | cond_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			os_unmasked_simd_support <= OSX_RESET;
		end else if (wr_take && adr_i == OFF_CTRL) begin
			os_unmasked_simd_support <= 1'(wb_merge(ctrl_word, dat_i, sel_i) >> CTRL_OSX_BIT);
		end
	end

	// ==========================================================
	// Interrupt status
	always_comb begin
		ev = '0;
		ev[EV_SIMD] = raise;
		ev[EV_INV_OP] = hit & ~os_unmasked_simd_support;
		ev[EV_MASKED] = (|cond_set) & ~hit;
		irq_clr = '0;
		if (wr_take && adr_i == OFF_IRQ_CLR && sel_i[0]) begin
			irq_clr = dat_i[IRQ_W-1:0];
		end
		next_irq_stat = (irq_stat & ~irq_clr) | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= IRQ_RESET;
			irq_en <= IRQ_RESET;
			irq_o <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_o <= |(next_irq_stat & irq_en);
			if (wr_take && adr_i == OFF_IRQ_EN && sel_i[0]) begin
				irq_en <= dat_i[IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// Read decode
	always_comb begin
		rd_word = '0;
		if (adr_i == OFF_CSR) begin
			rd_word = csr_word;
		end else if (adr_i == OFF_CTRL) begin
			rd_word = ctrl_word;
		end else if (adr_i == OFF_FAULT_IP) begin
			rd_word[IP_W-1:0] = fault_ip;
		end else if (adr_i == OFF_INFO) begin
			rd_word[7:0] = info_vec;
			rd_word[8 +: LANES] = info_lanes;
		end else if (adr_i == OFF_IRQ_STAT) begin
			rd_word[IRQ_W-1:0] = irq_stat;
		end else if (adr_i == OFF_IRQ_EN) begin
			rd_word[IRQ_W-1:0] = irq_en;
		end
	end

	// ==========================================================
	// Wishbone handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (cyc_i && stb_i && !ack_o && !we_i) begin
				dat_o <= rd_word;
			end
		end
	end

endmodule

// ### verilog/sfe_pkg.sv
// Package: constants for the packed floating-point exception unit.
// Assumes a 32-bit classic Wishbone register port and one core clock.
package sfe_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] OFF_CSR      = 5'h00;
	localparam logic [4:0] OFF_CTRL     = 5'h04;
	localparam logic [4:0] OFF_FAULT_IP = 5'h08;
	localparam logic [4:0] OFF_INFO     = 5'h0C;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFF_IRQ_EN   = 5'h14;
	localparam logic [4:0] OFF_IRQ_CLR  = 5'h18;

	// ==========================================================
	// Condition bit positions
	localparam int NCOND    = 6;
	localparam int C_INV    = 0;
	localparam int C_DENORM = 1;
	localparam int C_DIVZ   = 2;
	localparam int C_OVF    = 3;
	localparam int C_UNF    = 4;
	localparam int C_INEX   = 5;

	// ==========================================================
	// Control and status layout and reset values
	localparam int          CSR_FLAG_LSB = 0;
	localparam int          CSR_MASK_LSB = 7;
	localparam logic [5:0]  FLAG_RESET   = 6'h00;
	localparam logic [5:0]  MASK_RESET   = 6'h3F;
	localparam int          CTRL_OSX_BIT = 0;
	localparam logic        OSX_RESET    = 1'b0;

	// ==========================================================
	// Fault vectors
	localparam logic [7:0] VEC_SIMD_FP = 8'h13;
	localparam logic [7:0] VEC_INV_OP  = 8'h06;

	// ==========================================================
	// Interrupt events
	localparam int IRQ_W       = 3;
	localparam int EV_SIMD     = 0;
	localparam int EV_INV_OP   = 1;
	localparam int EV_MASKED   = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ==========================================================
	// Operation sequencing
	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_ARITH = 1'b1
	} sfe_state_t;

endpackage

// ### verilog/sfe_pre_lane.sv
// Pre-computation classifier for one sub-operand.
// Assumes operand class inputs are valid while the parent samples them.
module sfe_pre_lane
	import sfe_pkg::*;
(
	// Operand class
	input  wire logic             en_i,
	input  wire logic             nan_strict_i,
	input  wire logic             snan_i,
	input  wire logic             qnan_i,
	input  wire logic             inv_other_i,
	input  wire logic             div_zero_i,
	input  wire logic             denorm_i,
	input  wire logic [NCOND-1:0] mask_i,
	// Result
	output logic      [NCOND-1:0] flag_o,
	output logic                  unmasked_o,
	output logic                  block_o
);
	logic p1;
	logic p2;
	logic stop3;

	always_comb begin
		p1 = snan_i | (nan_strict_i & qnan_i);
		p2 = qnan_i & ~nan_strict_i;
		flag_o = '0;
		block_o = 1'b0;
		stop3 = 1'b0;
		if (en_i) begin
			if (p1) begin
				flag_o[C_INV] = 1'b1;
				block_o = 1'b1;
			end else if (p2) begin
				block_o = 1'b1;
			end else begin
				if (inv_other_i) begin
					flag_o[C_INV] = 1'b1;
					stop3 = ~mask_i[C_INV];
				end else if (div_zero_i) begin
					flag_o[C_DIVZ] = 1'b1;
					stop3 = ~mask_i[C_DIVZ];
				end
				if (stop3) begin
					block_o = 1'b1;
				end else if (denorm_i) begin
					flag_o[C_DENORM] = 1'b1;
					block_o = ~mask_i[C_DENORM];
				end
			end
		end
		unmasked_o = |(flag_o & ~mask_i);
	end
endmodule

// ### verilog/sfe_post_lane.sv
// Post-computation classifier for one sub-operand.
// Assumes result status is valid while the parent samples it.
module sfe_post_lane
	import sfe_pkg::*;
(
	// Result status
	input  wire logic             en_i,
	input  wire logic             overflow_i,
	input  wire logic             underflow_i,
	input  wire logic             inexact_i,
	input  wire logic [NCOND-1:0] mask_i,
	// Result
	output logic      [NCOND-1:0] flag_o,
	output logic                  unmasked_o
);
	always_comb begin
		flag_o = '0;
		if (en_i) begin
			if (overflow_i) begin
				flag_o[C_OVF] = 1'b1;
				flag_o[C_INEX] = inexact_i;
			end else if (underflow_i) begin
				flag_o[C_UNF] = 1'b1;
				flag_o[C_INEX] = inexact_i;
			end else if (inexact_i) begin
				flag_o[C_INEX] = 1'b1;
			end
		end
		unmasked_o = |(flag_o & ~mask_i);
	end
endmodule

// ### testbench/sfe_pipe_model.sv
// Pipeline model: result status for each operation that may proceed.
// Assumes proceed_i is the unit's one-cycle proceed pulse.
module sfe_pipe_model #(
	parameter int LANES = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Bench controls and unit verdict
	input  wire logic             proceed_i,
	input  wire logic [3:0]       delay_i,
	input  wire logic [LANES-1:0] ovf_i,
	input  wire logic [LANES-1:0] unf_i,
	input  wire logic [LANES-1:0] inx_i,
	// Result status
	output logic                  post_valid_o,
	output logic      [LANES-1:0] overflow_o,
	output logic      [LANES-1:0] underflow_o,
	output logic      [LANES-1:0] inexact_o
);
	// ==========
	// Arithmetic latency
	logic       armed;
	logic [3:0] cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed <= 1'b0;
			cnt   <= 4'h0;
		end else if (proceed_i) begin
			armed <= 1'b1;
			cnt   <= delay_i;
		end else if (armed) begin
			armed <= (cnt != 4'h0);
			cnt   <= cnt - 4'h1;
		end
	end
	// ==========
	// Status only after arithmetic, inverted noise otherwise
	assign post_valid_o = armed && (cnt == 4'h0);
	assign overflow_o   = post_valid_o ? ovf_i : ~ovf_i;
	assign underflow_o  = post_valid_o ? unf_i : ~unf_i;
	assign inexact_o    = post_valid_o ? inx_i : ~inx_i;
endmodule

// ### testbench/sfe_exception_checker.sv
// Checker: bus, verdict and fault relations at the unit's ports.
// Assumes a bind to sfe_exception_unit; one clock, reset high.
module sfe_exception_checker
	import sfe_pkg::*;
#(
	parameter int LANES = 4,
	parameter int IP_W  = 32
) (
	// Clock, reset, bus
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire logic            cyc_i,
	input wire logic            stb_i,
	input wire logic            ack_o,
	// Pipeline and faults
	input wire logic            pre_valid_i,
	input wire logic [IP_W-1:0] instr_ptr_i,
	input wire logic            post_valid_i,
	input wire logic            pre_done_o,
	input wire logic            proceed_o,
	input wire logic            post_done_o,
	input wire logic            simd_fp_fault_o,
	input wire logic            invalid_opcode_fault_o,
	input wire logic [7:0]      fault_vector_o,
	input wire logic [IP_W-1:0] fault_ip_o,
	input wire logic            error_code_push_o
);
	// ==========
	// Awaiting result status
	logic busy;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy <= 1'b0;
		end else if (proceed_o || post_done_o) begin
			busy <= proceed_o;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_pre_take;
		pre_valid_i && !busy && !proceed_o;
	endsequence
	sequence s_pre_fault;
		pre_done_o && simd_fp_fault_o;
	endsequence
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("ack held past one cycle");
	ack_lat_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus answer missing");
	pre_lat_a: assert property (s_pre_take |=> pre_done_o)
		else $error("operand verdict missing");
	post_lat_a: assert property (post_valid_i && busy |=> post_done_o)
		else $error("result verdict missing");
	proc_clean_a: assert property (
		proceed_o |-> pre_done_o && !simd_fp_fault_o && !invalid_opcode_fault_o)
		else $error("proceed together with a fault");
	simd_vec_a: assert property (
		simd_fp_fault_o |-> fault_vector_o == VEC_SIMD_FP && !invalid_opcode_fault_o)
		else $error("simd fault vector wrong");
	inv_vec_a: assert property (
		invalid_opcode_fault_o |-> fault_vector_o == VEC_INV_OP)
		else $error("invalid opcode vector wrong");
	fault_ip_a: assert property (
		s_pre_take ##1 s_pre_fault |-> fault_ip_o == $past(instr_ptr_i))
		else $error("fault pointer wrong");
	fault_inst_a: assert property (
		simd_fp_fault_o || invalid_opcode_fault_o |-> pre_done_o && !proceed_o || post_done_o)
		else $error("fault outside a verdict");
	no_errcode_a: assert property (!error_code_push_o)
		else $error("error code pushed");
endmodule

bind sfe_exception_unit sfe_exception_checker #(.LANES(LANES), .IP_W(IP_W)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.pre_valid_i(pre_valid_i), .instr_ptr_i(instr_ptr_i), .post_valid_i(post_valid_i),
	.pre_done_o(pre_done_o), .proceed_o(proceed_o), .post_done_o(post_done_o),
	.simd_fp_fault_o(simd_fp_fault_o), .invalid_opcode_fault_o(invalid_opcode_fault_o),
	.fault_vector_o(fault_vector_o), .fault_ip_o(fault_ip_o),
	.error_code_push_o(error_code_push_o)
);

// ### testbench/tb_top.sv
// Testbench: register, verdict and fault scenarios for the exception unit.
// Assumes the pipeline model answers each proceed with result status.
module tb_top
	import sfe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Signals
	localparam int LANES = 4;
	logic              clk_i = 1'b0, rst_i = 1'b1;
	logic              cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [ADDR_W-1:0] adr_i = 5'h00;
	logic [3:0]        sel_i = 4'hF;
	logic [DATA_W-1:0] dat_i = 32'h0, dat_o;
	logic              pre_valid_i = 1'b0, nan_strict_i = 1'b0;
	logic [LANES-1:0]  lane_en_i = 4'hF, snan_i = 4'h0, qnan_i = 4'h0, inv_other_i = 4'h0;
	logic [LANES-1:0]  div_zero_i = 4'h0, denorm_i = 4'h0, p_ovf = 4'h0, p_unf = 4'h0;
	logic [LANES-1:0]  p_inx = 4'h0, overflow_i, underflow_i, inexact_i, default_lanes_o;
	logic [3:0]        p_dly = 4'h0;
	logic [31:0]       instr_ptr_i = 32'h0, fault_ip_o;
	logic              ack_o, post_valid_i, pre_done_o, proceed_o, post_done_o;
	logic              simd_fp_fault_o, invalid_opcode_fault_o, error_code_push_o, irq_o;
	logic [7:0]        fault_vector_o;
	int                num_errors = 0;
	int                compares = 0;

	always #10 clk_i = ~clk_i;
	// ==========
	// Unit and pipeline model
	sfe_exception_unit #(.LANES(LANES), .IP_W(32)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pre_valid_i(pre_valid_i), .lane_en_i(lane_en_i), .nan_strict_i(nan_strict_i),
		.snan_i(snan_i), .qnan_i(qnan_i), .inv_other_i(inv_other_i),
		.div_zero_i(div_zero_i), .denorm_i(denorm_i), .instr_ptr_i(instr_ptr_i),
		.post_valid_i(post_valid_i), .overflow_i(overflow_i), .underflow_i(underflow_i),
		.inexact_i(inexact_i), .pre_done_o(pre_done_o), .proceed_o(proceed_o),
		.post_done_o(post_done_o), .default_lanes_o(default_lanes_o),
		.simd_fp_fault_o(simd_fp_fault_o), .invalid_opcode_fault_o(invalid_opcode_fault_o),
		.fault_vector_o(fault_vector_o), .fault_ip_o(fault_ip_o),
		.error_code_push_o(error_code_push_o), .irq_o(irq_o)
	);
	sfe_pipe_model #(.LANES(LANES)) u_pipe (
		.clk_i(clk_i), .rst_i(rst_i), .proceed_i(proceed_o), .delay_i(p_dly),
		.ovf_i(p_ovf), .unf_i(p_unf), .inx_i(p_inx), .post_valid_o(post_valid_i),
		.overflow_o(overflow_i), .underflow_o(underflow_i), .inexact_o(inexact_i)
	);
	// ==========
	// Shared tasks
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		chk("bus ack", 32'h1, {31'h0, ack_o});
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string s);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(s, e, q);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	// Classes packed as snan, qnan, other invalid, divide, denormal
	task automatic pre_op(input logic [19:0] c, input logic st, input logic [31:0] ip,
			output logic [2:0] r);
		int n;
		@(posedge clk_i);
		pre_valid_i <= 1'b1;
		{snan_i, qnan_i, inv_other_i, div_zero_i, denorm_i} <= c;
		nan_strict_i <= st;
		instr_ptr_i <= ip;
		@(posedge clk_i);
		pre_valid_i <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (pre_done_o !== 1'b1 && n < 8);
		chk("operand verdict", 32'h1, {31'h0, pre_done_o});
		r = {proceed_o, invalid_opcode_fault_o, simd_fp_fault_o};
	endtask
	task automatic post_wait(input logic pr, output logic [2:0] r);
		int n;
		r = 3'b000;
		n = 0;
		if (pr) begin
			do begin
				@(negedge clk_i);
				n++;
			end while (post_done_o !== 1'b1 && n < 30);
			chk("result verdict", 32'h1, {31'h0, post_done_o});
			r = {1'b0, invalid_opcode_fault_o, simd_fp_fault_o};
		end
	endtask
	// ==========
	// Scenarios
	task automatic t_regs();
		rd(OFF_CSR, 32'h00001F80, "csr reset");
		rd(OFF_CTRL, 32'h00000000, "ctrl reset");
		wr(OFF_FAULT_IP, 32'hFFFFFFFF);
		rd(OFF_FAULT_IP, 32'h00000000, "fault ip read only");
		wr(5'h1C, 32'hFFFFFFFF);
		rd(5'h1C, 32'h00000000, "unmapped");
	endtask
	task automatic t_masked();
		logic [2:0] r;
		p_ovf <= 4'h4;
		p_inx <= 4'hC;
		p_dly <= 4'h8;
		pre_op(20'h00022, 1'b0, 32'h00001000, r);
		chk("masked pre", 32'h4, {29'h0, r});
		rd(OFF_CSR, 32'h00001F86, "pre flags");
		post_wait(r[2], r);
		chk("masked post", 32'h0, {29'h0, r});
		rd(OFF_CSR, 32'h00001FAE, "post flags");
		rd(OFF_IRQ_STAT, 32'h00000004, "irq status");
		wr(OFF_IRQ_EN, 32'h00000004);
		rd(OFF_IRQ_EN, 32'h00000004, "irq enable");
		chk("irq raised", 32'h1, {31'h0, irq_o});
		wr(OFF_IRQ_CLR, 32'h00000004);
		rd(OFF_IRQ_STAT, 32'h00000000, "irq cleared");
		chk("irq dropped", 32'h0, {31'h0, irq_o});
	endtask
	task automatic t_prio();
		logic [2:0] r;
		p_ovf <= 4'h0;
		p_inx <= 4'h0;
		p_dly <= 4'h1;
		wr(OFF_CSR, 32'h00001D80);
		wr(OFF_CTRL, 32'h00000001);
		pre_op(20'h10010, 1'b0, 32'h00002000, r);
		chk("snan over divide", 32'h4, {29'h0, r});
		post_wait(r[2], r);
		pre_op(20'h01010, 1'b1, 32'h00002004, r);
		chk("strict nan", 32'h4, {29'h0, r});
		post_wait(r[2], r);
		pre_op(20'h02020, 1'b0, 32'h00002008, r);
		chk("qnan over divide", 32'h4, {29'h0, r});
		chk("qnan lane", 32'h2, {28'h0, default_lanes_o});
		post_wait(r[2], r);
		lane_en_i <= 4'h3;
		pre_op(20'h00004, 1'b0, 32'h0000200C, r);
		chk("two lanes", 32'h0, {28'h0, default_lanes_o});
		post_wait(r[2], r);
		lane_en_i <= 4'hF;
		rd(OFF_CSR, 32'h00001D81, "priority flags");
	endtask
	task automatic t_fault();
		logic [2:0] r;
		pre_op(20'h00040, 1'b0, 32'hA5A50040, r);
		chk("simd fault", 32'h1, {29'h0, r});
		chk("simd vector", 32'h13, {24'h0, fault_vector_o});
		chk("fault pointer", 32'hA5A50040, fault_ip_o);
		chk("error code", 32'h0, {31'h0, error_code_push_o});
		rd(OFF_CSR, 32'h00001D85, "fault flags");
		wr(OFF_CTRL, 32'h00000000);
		pre_op(20'h00010, 1'b0, 32'hA5A50044, r);
		chk("invalid opcode", 32'h2, {29'h0, r});
		chk("opcode vector", 32'h06, {24'h0, fault_vector_o});
		rd(OFF_INFO, 32'h00000106, "fault info");
		pre_op(20'h00000, 1'b0, 32'hA5A50048, r);
		chk("next op clean", 32'h4, {29'h0, r});
		post_wait(r[2], r);
	endtask
	task automatic t_unmask();
		logic [2:0] r;
		int         n;
		wr(OFF_CSR, 32'h00001B05);
		n = 0;
		repeat (10) begin
			@(negedge clk_i);
			if (simd_fp_fault_o !== 1'b0 || invalid_opcode_fault_o !== 1'b0) n++;
		end
		chk("unmask quiet", 32'h0, n);
		wr(OFF_CTRL, 32'h00000001);
		p_ovf <= 4'h1;
		p_dly <= 4'h0;
		pre_op(20'h00000, 1'b0, 32'h0000C0DE, r);
		post_wait(r[2], r);
		chk("result fault", 32'h1, {29'h0, r});
		chk("result pointer", 32'h0000C0DE, fault_ip_o);
	endtask
	// ==========
	// Run control
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_masked();
		t_prio();
		t_fault();
		t_unmask();
		end_of_test();
	end
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end
endmodule
